//--- hw/ptr_table_read.sv
// Table read unit: returns one program memory byte into the holding latch.
// Assumes the core issues one command per cycle while busy is low.
`timescale 1ns/10ps
`default_nettype none
`include "ptr_cfg.svh"
// Behaviour
// - The table pointer is 21 bits wide and spans a 2-Mbyte program space.
// - Any address above implemented memory reads back as all zero bits.
// - Implemented memory is 64 Kbytes, that is 32,768 single-word entries.
// - The program store has its own port, independent of data space.
// - Each table read moves exactly one byte into the latch.
// - A table read copies the byte at the pointer into the latch.
// - Variants adjust the pointer before or after the read, pre-increment included.
// - The pointer's low bit picks the high or low byte of the word.
module ptr_table_read
   import ptr_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   ptr_upper_we_i,
   input  wire logic                   ptr_high_we_i,
   input  wire logic                   ptr_low_we_i,
   input  wire logic [`PTR_BYTE_W-1:0] ptr_wdata_i,
   input  wire logic                   table_read_instruction_i,
   input  wire logic [1:0]             read_mode_i,
   input  wire logic                   load_en_i,
   input  wire logic [`PTR_WIDX_W-1:0] load_idx_i,
   input  wire logic [`PTR_WORD_W-1:0] load_word_i,
   output logic [`PTR_ADDR_W-1:0]      table_byte_pointer_o,
   output logic [`PTR_BYTE_W-1:0]      table_holding_latch_o,
   output logic                        busy_o,
   output logic                        done_o
);
   typedef struct packed {
      ptr_state_type st;
      ptr_addr_type  ptr;
      ptr_byte_type  lat;
      logic          done;
      logic          busy;
   } ptr_regs_type;

   ptr_regs_type r_reg, r_next;
   logic [1:0]   rst_sync_reg;
   logic         rst_n;
   logic [`PTR_WORD_W-1:0] word;
   ptr_byte_type sel_byte;

   // Reset is released through two flops so every state flop sees it clean.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // Dedicated store port keeps table reads off the data bus.
   ptr_word_rom u_rom (
      .clk_i       (clk_i),
      .load_en_i   (load_en_i),
      .load_idx_i  (load_idx_i),
      .load_word_i (load_word_i),
      .rd_idx_i    (r_reg.ptr[`PTR_WIDX_W:1]),
      .rd_word_o   (word)
   );

   // Byte pick and zero fill beyond the implemented top.
   always_comb begin
      if (r_reg.ptr > `PTR_IMPL_TOP) begin
         sel_byte = `PTR_ZERO_BYTE;
      end else if (r_reg.ptr[0]) begin
         sel_byte = word[15:8];
      end else begin
         sel_byte = word[7:0];
      end
   end

   // Next state: pointer loads, then a read captures one byte and adjusts.
   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      case (r_reg.st)
         PTR_IDLE: begin
            if (ptr_upper_we_i) begin
               r_next.ptr[20:16] = ptr_wdata_i[4:0];
            end
            if (ptr_high_we_i) begin
               r_next.ptr[15:8] = ptr_wdata_i;
            end
            if (ptr_low_we_i) begin
               r_next.ptr[7:0] = ptr_wdata_i;
            end
            if (table_read_instruction_i) begin
               if (read_mode_i == `PTR_TBL_RD_PRE) begin
                  r_next.ptr = r_reg.ptr + `PTR_ONE_ADDR;
               end
               r_next.st = PTR_READ;
            end
         end
         PTR_READ: begin
            r_next.lat  = sel_byte;
            r_next.done = 1'b1;
            case (read_mode_i)
               `PTR_TBL_RD_INC: r_next.ptr = r_reg.ptr + `PTR_ONE_ADDR;
               `PTR_TBL_RD_DEC: r_next.ptr = r_reg.ptr - `PTR_ONE_ADDR;
               default:         r_next.ptr = r_reg.ptr;
            endcase
            r_next.st = PTR_DONE;
         end
         PTR_DONE: begin
            r_next.st = PTR_IDLE;
         end
         default: begin
            r_next.st = PTR_IDLE;
         end
      endcase
      // Busy is registered from the next state so the pin has no decode.
      r_next.busy = (r_next.st != PTR_IDLE);
   end

   // Single state register; the pointer wraps within 21 bits by width.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '{PTR_IDLE, `PTR_ZERO_ADDR, `PTR_ZERO_BYTE, 1'b0, 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign table_byte_pointer_o  = r_reg.ptr;
   assign table_holding_latch_o = r_reg.lat;
   assign busy_o                = r_reg.busy;
   assign done_o                = r_reg.done;

   a_zero_fill: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_READ && r_reg.ptr > `PTR_IMPL_TOP)
      |=> table_holding_latch_o == `PTR_ZERO_BYTE)
      else $error("Unimplemented address did not read zero.");

   a_byte_pick: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_READ && r_reg.ptr <= `PTR_IMPL_TOP)
      |=> table_holding_latch_o ==
          ($past(r_reg.ptr[0]) ? $past(word[15:8]) : $past(word[7:0])))
      else $error("Latched byte does not match pointer low bit.");

   a_post_inc: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_READ && read_mode_i == `PTR_TBL_RD_INC)
      |=> table_byte_pointer_o == $past(r_reg.ptr) + `PTR_ONE_ADDR)
      else $error("Post-increment did not advance pointer.");

   a_read_done: assert property (@(posedge clk_i) disable iff (!rst_n)
      (table_read_instruction_i && r_reg.st == PTR_IDLE)
      |=> ##1 done_o ##1 !done_o)
      else $error("Read did not finish with one done pulse.");

   a_plain_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_READ && read_mode_i == `PTR_TBL_RD)
      |=> $stable(table_byte_pointer_o))
      else $error("Plain read changed the pointer.");

   a_upper_load: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_IDLE && ptr_upper_we_i && !table_read_instruction_i)
      |=> table_byte_pointer_o[20:16] == $past(ptr_wdata_i[4:0]))
      else $error("Upper pointer byte not loaded.");

   a_low_load: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_IDLE && ptr_low_we_i && !table_read_instruction_i)
      |=> table_byte_pointer_o[7:0] == $past(ptr_wdata_i))
      else $error("Low pointer byte not loaded.");

   a_busy_span: assert property (@(posedge clk_i) disable iff (!rst_n)
      (table_read_instruction_i && !busy_o) |=> busy_o [*2] ##1 !busy_o)
      else $error("Busy span is not two cycles.");

   // Post-decrement walks the pointer back by one byte.
   a_post_dec: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_READ && read_mode_i == `PTR_TBL_RD_DEC)
      |=> table_byte_pointer_o == $past(r_reg.ptr) - `PTR_ONE_ADDR)
      else $error("Post-decrement did not step pointer back.");

   // Pre-increment moves the pointer before the store is read.
   a_pre_inc: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_IDLE && table_read_instruction_i &&
       read_mode_i == `PTR_TBL_RD_PRE)
      |=> table_byte_pointer_o == $past(r_reg.ptr) + `PTR_ONE_ADDR)
      else $error("Pre-increment did not advance pointer.");

   // The middle pointer byte lands only while the unit is idle.
   a_high_load: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_IDLE && ptr_high_we_i && !table_read_instruction_i)
      |=> table_byte_pointer_o[15:8] == $past(ptr_wdata_i))
      else $error("High pointer byte not loaded.");

   // Writes in the closing cycle are refused, so the pointer holds.
   a_done_refuse: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st == PTR_DONE) |=> $stable(table_byte_pointer_o))
      else $error("Pointer changed while the unit was busy.");

   // Only the read cycle may change the latch: one byte per command.
   a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r_reg.st != PTR_READ) |=> $stable(table_holding_latch_o))
      else $error("Latch changed outside a read.");

   // Done always falls inside the busy span the core waits on.
   a_done_busy: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o |-> busy_o)
      else $error("Done pulse seen while not busy.");

   // A corrupt state code falls back to idle; keep exactly one bit set.
   a_state_code: assert property (@(posedge clk_i) disable iff (!rst_n)
      $onehot(r_reg.st))
      else $error("State register is not one-hot.");
endmodule
`default_nettype wire

//--- hw/ptr_cfg.svh
// Constants for the program memory table read block.
// Assumes inclusion by the package and design files by bare name.
`ifndef PTR_CFG_SVH
`define PTR_CFG_SVH
`define PTR_ADDR_W      21
`define PTR_WORD_W      16
`define PTR_BYTE_W      8
`define PTR_IMPL_WORDS  32768
`define PTR_WIDX_W      15
`define PTR_IMPL_TOP    21'h00FFFF
`define PTR_TBL_RD      2'h0
`define PTR_TBL_RD_INC  2'h1
`define PTR_TBL_RD_DEC  2'h2
`define PTR_TBL_RD_PRE  2'h3
`define PTR_ZERO_BYTE   8'h00
`define PTR_ZERO_ADDR   21'h000000
`define PTR_ONE_ADDR    21'h000001
`endif

//--- hw/ptr_pkg.sv
// Types shared by the program memory table read block.
// Assumes ptr_cfg.svh is on the include path.
`include "ptr_cfg.svh"
package ptr_pkg;
   typedef logic [`PTR_ADDR_W-1:0] ptr_addr_type;
   typedef logic [`PTR_BYTE_W-1:0] ptr_byte_type;
   typedef enum logic [2:0] {
      PTR_IDLE = 3'h1,
      PTR_READ = 3'h2,
      PTR_DONE = 3'h4
   } ptr_state_type;
endpackage

//--- hw/ptr_word_rom.sv
// Word-organised program store with its own read port.
// Assumes the core loads the contents through the load port.
`timescale 1ns/10ps
`default_nettype none
`include "ptr_cfg.svh"
module ptr_word_rom
   import ptr_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       load_en_i,
   input  wire logic [`PTR_WIDX_W-1:0]     load_idx_i,
   input  wire logic [`PTR_WORD_W-1:0]     load_word_i,
   input  wire logic [`PTR_WIDX_W-1:0]     rd_idx_i,
   output logic      [`PTR_WORD_W-1:0]     rd_word_o
);
   logic [`PTR_WORD_W-1:0] mem_reg [`PTR_IMPL_WORDS];

   // Storage has no reset; contents are defined by the load port.
   always_ff @(posedge clk_i) begin
      if (load_en_i) begin
         mem_reg[load_idx_i] <= load_word_i;
      end
   end

   // Combinational read so the top registers the selected byte once.
   assign rd_word_o = mem_reg[rd_idx_i];
endmodule
`default_nettype wire

//--- bench/ptr_core_model.sv
// Core-side model issuing pointer loads, store loads and table reads.
// Assumes callers leave the read spacing that the unit needs.
`timescale 1ns/10ps
`default_nettype none
module ptr_core_model
   import ptr_pkg::*;
(
   input  wire logic        clk_i,
   output logic             up_we_o,
   output logic             hi_we_o,
   output logic             lo_we_o,
   output logic [7:0]       wdata_o,
   output logic             rd_o,
   output logic [1:0]       mode_o,
   output logic             ld_en_o,
   output logic [14:0]      ld_idx_o,
   output logic [15:0]      ld_word_o
);
   // All strobes idle at time zero so nothing is taken during reset.
   initial begin
      {up_we_o, hi_we_o, lo_we_o, rd_o, ld_en_o} = 5'h00;
      wdata_o = 8'h00;
      mode_o = 2'h0;
      ld_idx_o = 15'h0000;
      ld_word_o = 16'h0000;
   end
   // Every change lands one fixed delay after the rising edge.
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   // The pointer goes in as three bytes, upper first.
   task automatic set_ptr(input ptr_addr_type a);
      step();
      up_we_o = 1'b1;
      wdata_o = {3'h0, a[20:16]};
      step();
      up_we_o = 1'b0;
      hi_we_o = 1'b1;
      wdata_o = a[15:8];
      step();
      hi_we_o = 1'b0;
      lo_we_o = 1'b1;
      wdata_o = a[7:0];
      step();
      lo_we_o = 1'b0;
   endtask
   // One word into the store.
   task automatic load(input logic [14:0] i, input logic [15:0] w);
      step();
      {ld_en_o, ld_idx_o, ld_word_o} = {1'b1, i, w};
      step();
      ld_en_o = 1'b0;
   endtask
   // One-cycle read pulse; the mode stays until the next read.
   task automatic rd(input logic [1:0] m);
      step();
      mode_o = m;
      rd_o = 1'b1;
      step();
      rd_o = 1'b0;
      repeat (2) step();
   endtask
endmodule
`default_nettype wire

//--- bench/program_memory_table_read_test.sv
// Self-checking bench for the table read unit.
// Assumes the core model file is compiled before this one.
`timescale 1ns/10ps
`default_nettype none
`include "ptr_cfg.svh"
module program_memory_table_read_test;
   import ptr_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, uw, hw, lw, rd, le, busy, done;
   logic [7:0] wd, lat;
   logic [1:0] md;
   logic [14:0] li;
   logic [15:0] lword, mem [0:32767];
   ptr_addr_type ptr, p;
   logic [28:0] q[$], e;
   int fails = 0, total_checks = 0, seed = 71;
   always #20 clk_i = ~clk_i;
   ptr_core_model i_core (.clk_i(clk_i), .up_we_o(uw), .hi_we_o(hw),
      .lo_we_o(lw), .wdata_o(wd), .rd_o(rd), .mode_o(md), .ld_en_o(le),
      .ld_idx_o(li), .ld_word_o(lword));
   ptr_table_read i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .ptr_upper_we_i(uw), .ptr_high_we_i(hw), .ptr_low_we_i(lw),
      .ptr_wdata_i(wd), .table_read_instruction_i(rd), .read_mode_i(md),
      .load_en_i(le), .load_idx_i(li), .load_word_i(lword),
      .table_byte_pointer_o(ptr), .table_holding_latch_o(lat),
      .busy_o(busy), .done_o(done));
   task automatic close_out();
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string n, input logic [28:0] x, y);
      total_checks++;
      if (x !== y) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, x, y);
      end
   endtask
   // Reference read: the address, byte pick and pointer change per mode.
   task automatic do_rd(input logic [1:0] m);
      ptr_addr_type a;
      logic [15:0] w;
      a = (m == `PTR_TBL_RD_PRE) ? p + 21'h000001 : p;
      w = (a > `PTR_IMPL_TOP) ? 16'h0000 : mem[a[15:1]];
      p = (m == `PTR_TBL_RD_INC) ? p + 21'h000001 :
          (m == `PTR_TBL_RD_DEC) ? p - 21'h000001 : a;
      q.push_back({a[0] ? w[15:8] : w[7:0], p});
      i_core.rd(m);
   endtask
   // Each done pulse takes the oldest note; done stands one cycle.
   always @(negedge clk_i) if (done === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 29'h1FFFFFFF;
      check("latch", e[28:21], lat);
      check("pointer", e[20:0], ptr);
      check("busy", 29'h00000001, {28'h0000000, busy});
   end
   // Top words of the store, wrapping to word zero.
   initial begin
      #50;
      check("reset outputs", 29'h00000000, {lat, ptr});
      repeat (2) i_core.step();
      rst_n_i = 1'b1;
      repeat (3) i_core.step();
      for (int i = 0; i < 8; i++) begin
         li = 15'h7FFC + i[14:0];
         mem[li] = $random(seed);
         i_core.load(li, mem[li]);
      end
      p = 21'h00FFF8;
      i_core.set_ptr(p);
      for (int i = 0; i < 14; i++) do_rd(2'(28'h55553AB >> (26 - 2 * i)));
      p = 21'h1FFFFF;
      i_core.set_ptr(p);
      i_core.step();
      check("pointer load", {8'h00, p}, {8'h00, ptr});
      repeat (3) do_rd(`PTR_TBL_RD_INC);
      repeat (4) i_core.step();
      check("pending notes", 29'h00000000, 29'(q.size()));
      close_out();
   end
   initial begin
      #20000;
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
